/* rtl/gpm_pkg.sv */
/*
 * constants for the pin output source multiplexer: register indices,
 * field positions, reset values and source/select encodings.
 * assumes a 32-bit apb slave with one aligned word per register.
 */
package gpm_pkg;

    // bus geometry
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned NUM_RX_PORTS = 4;
    localparam int unsigned NUM_REMOTE_PINS = 4;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PIN_CTRL = 10'h015;
    localparam logic [9:0] IDX_PORT_CFG = 10'h020;
    localparam logic [9:0] IDX_PIN_STATUS = 10'h021;
    localparam logic [11:0] ADDR_PIN_CTRL = {IDX_PIN_CTRL, 2'h0};
    localparam logic [11:0] ADDR_PORT_CFG = {IDX_PORT_CFG, 2'h0};
    localparam logic [11:0] ADDR_PIN_STATUS = {IDX_PIN_STATUS, 2'h0};

    // pin_output_control fields
    localparam int unsigned CTRL_OE_BIT = 0;
    localparam int unsigned CTRL_VAL_BIT = 1;
    localparam int unsigned CTRL_SRC_LSB = 2;
    localparam int unsigned CTRL_SRC_MSB = 4;
    localparam int unsigned CTRL_SEL_LSB = 5;
    localparam int unsigned CTRL_SEL_MSB = 7;

    // port configuration fields
    localparam int unsigned CFG_EN_LSB = 0;
    localparam int unsigned CFG_EN_MSB = 3;
    localparam int unsigned CFG_TXSEL_LSB = 4;
    localparam int unsigned CFG_TXSEL_MSB = 7;

    // reset values
    localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
    localparam logic [7:0] PORT_CFG_RESET = 8'hFF;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [23:0] PAD24 = 24'h00_0000;
    localparam logic [29:0] PAD30 = 30'h0000_0000;

    // output source codes
    localparam logic [2:0] SRC_RX0 = 3'h0;
    localparam logic [2:0] SRC_RX1 = 3'h1;
    localparam logic [2:0] SRC_RX2 = 3'h2;
    localparam logic [2:0] SRC_RX3 = 3'h3;
    localparam logic [2:0] SRC_STATUS = 3'h4;
    localparam logic [2:0] SRC_TX = 3'h6;

    // select codes, receive port source
    localparam logic [2:0] SEL_RX_PIN0 = 3'h0;
    localparam logic [2:0] SEL_RX_PIN1 = 3'h1;
    localparam logic [2:0] SEL_RX_PIN2 = 3'h2;
    localparam logic [2:0] SEL_RX_PIN3 = 3'h3;
    localparam logic [2:0] SEL_RX_LOCK = 3'h4;
    localparam logic [2:0] SEL_RX_PASS = 3'h5;
    localparam logic [2:0] SEL_RX_FV = 3'h6;
    localparam logic [2:0] SEL_RX_LV = 3'h7;

    // select codes, device status source
    localparam logic [2:0] SEL_ST_VAL = 3'h0;
    localparam logic [2:0] SEL_ST_LOCK_ANY = 3'h1;
    localparam logic [2:0] SEL_ST_PASS_ALL = 3'h2;
    localparam logic [2:0] SEL_ST_FSYNC = 3'h4;

    // select codes, transmit port source
    localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
    localparam logic [2:0] SEL_TX_PASS_OR = 3'h1;
    localparam logic [2:0] SEL_TX_FV = 3'h2;
    localparam logic [2:0] SEL_TX_LV = 3'h3;
    localparam logic [2:0] SEL_TX_SYNC = 3'h4;
    localparam logic [2:0] SEL_TX_IRQ = 3'h5;

endpackage

/* rtl/gpm_cfg_if.sv */
/*
 * configuration carrier from the register file to the source multiplexer and the port reduction.
 * assumes one driver (the top) and readers on the same clock.
 */
interface gpm_cfg_if;
    logic [7:0] pin_ctrl;
    logic [3:0] rx_enable;
    logic [3:0] tx_pass_sel;

    modport src (
        output pin_ctrl,
        output rx_enable,
        output tx_pass_sel
    );

    modport dst (
        input pin_ctrl,
        input rx_enable,
        input tx_pass_sel
    );
endinterface

/* rtl/gpm_port_reduce.sv */
/*
 * per-port masking and reduction of lock and pass indications.
 * assumes the indications are synchronous to the register clock.
 */
module gpm_port_reduce (
    // per-port indications
    input wire logic [3:0] lock_i,
    input wire logic [3:0] pass_i,
    // masks
    input wire logic [3:0] enable_i,
    input wire logic [3:0] tx_sel_i,
    // reductions
    output logic lock_any_o,
    output logic pass_all_o,
    output logic tx_pass_and_o,
    output logic tx_pass_or_o
);
    logic [3:0] lock_m;
    logic [3:0] pass_m;
    logic [3:0] txand_m;
    logic [3:0] txor_m;

    // masked ports are neutral: zero for or, one for and
    for (genvar p = 0; p < 4; p++) begin : g_port
        assign lock_m[p] = lock_i[p] & enable_i[p];
        assign pass_m[p] = pass_i[p] | ~enable_i[p];
        assign txand_m[p] = pass_i[p] | ~tx_sel_i[p];
        assign txor_m[p] = pass_i[p] & tx_sel_i[p];
    end

    assign lock_any_o = |lock_m;
    assign pass_all_o = &pass_m;
    assign tx_pass_and_o = &txand_m;
    assign tx_pass_or_o = |txor_m;
endmodule

/* rtl/gpm_src_mux.sv */
/*
 * combinational source and select multiplexer for one pin.
 * assumes all inputs share the register clock; result is registered by the top.
 */
module gpm_src_mux (
    // configuration
    gpm_cfg_if.dst cfg,
    // receive port signals
    input wire logic [3:0][3:0] rx_remote_pin_i,
    input wire logic [3:0] rx_lock_i,
    input wire logic [3:0] rx_pass_i,
    input wire logic [3:0] rx_frame_valid_i,
    input wire logic [3:0] rx_line_valid_i,
    // reductions and device signals
    input wire logic lock_any_i,
    input wire logic pass_all_i,
    input wire logic tx_pass_and_i,
    input wire logic tx_pass_or_i,
    input wire logic frame_sync_pulse_i,
    input wire logic tx_frame_valid_i,
    input wire logic tx_line_valid_i,
    input wire logic tx_synced_i,
    input wire logic tx_irq_i,
    // selected level
    output logic mux_o
);
    logic [2:0] src;
    logic [2:0] sel;
    logic [1:0] port;

    assign src = cfg.pin_ctrl[gpm_pkg::CTRL_SRC_MSB:gpm_pkg::CTRL_SRC_LSB];
    assign sel = cfg.pin_ctrl[gpm_pkg::CTRL_SEL_MSB:gpm_pkg::CTRL_SEL_LSB];
    assign port = src[1:0];

    always_comb begin
        mux_o = 1'b0;
        unique case (src) // [R1]
            gpm_pkg::SRC_RX0, gpm_pkg::SRC_RX1, gpm_pkg::SRC_RX2, gpm_pkg::SRC_RX3: begin
                unique case (sel)
                    gpm_pkg::SEL_RX_PIN0, gpm_pkg::SEL_RX_PIN1,
                    gpm_pkg::SEL_RX_PIN2, gpm_pkg::SEL_RX_PIN3: begin
                        mux_o = rx_remote_pin_i[port][sel[1:0]]; // [R2]
                    end
                    gpm_pkg::SEL_RX_LOCK: mux_o = rx_lock_i[port]; // [R3]
                    gpm_pkg::SEL_RX_PASS: mux_o = rx_pass_i[port]; // [R3]
                    gpm_pkg::SEL_RX_FV: mux_o = rx_frame_valid_i[port]; // [R4]
                    gpm_pkg::SEL_RX_LV: mux_o = rx_line_valid_i[port]; // [R4]
                endcase
            end
            gpm_pkg::SRC_STATUS: begin
                unique case (sel)
                    gpm_pkg::SEL_ST_VAL: mux_o = cfg.pin_ctrl[gpm_pkg::CTRL_VAL_BIT]; // [R5] [R12]
                    gpm_pkg::SEL_ST_LOCK_ANY: mux_o = lock_any_i; // [R6]
                    gpm_pkg::SEL_ST_PASS_ALL: mux_o = pass_all_i; // [R7]
                    gpm_pkg::SEL_ST_FSYNC: mux_o = frame_sync_pulse_i; // [R8]
                    default: mux_o = 1'b0; // [R16]
                endcase
            end
            gpm_pkg::SRC_TX: begin
                unique case (sel)
                    gpm_pkg::SEL_TX_PASS_AND: mux_o = tx_pass_and_i; // [R9]
                    gpm_pkg::SEL_TX_PASS_OR: mux_o = tx_pass_or_i; // [R9]
                    gpm_pkg::SEL_TX_FV: mux_o = tx_frame_valid_i; // [R10]
                    gpm_pkg::SEL_TX_LV: mux_o = tx_line_valid_i; // [R10]
                    gpm_pkg::SEL_TX_SYNC: mux_o = tx_synced_i; // [R11]
                    gpm_pkg::SEL_TX_IRQ: mux_o = tx_irq_i; // [R11]
                    default: mux_o = 1'b0; // [R16]
                endcase
            end
            default: mux_o = 1'b0; // [R16]
        endcase
    end
endmodule

/* rtl/gpm_top.sv */
/*
 * top of the pin output source multiplexer: apb register file, reductions,
 * source multiplexer and registered pin driver.
 * assumes every source signal is produced by logic on clk_sys_i, so no
 * synchroniser is placed on them; the pin is output only.
 */
// The implementer's own choices: the APB register port and the register offsets.
// Functional notes
// (R1) Source field bits 4:2 pick receive port 0-3 (000-011), device status (100) or transmit port (110).
// (R2) With a receive port as source, select 000-011 drives that port's remote pins 0-3.
// (R3) With a receive port as source, select 100 drives its lock and 101 its pass indication.
// (R4) With a receive port as source, select 110 drives its frame valid and 111 its line valid.
// (R5) With device status as source, select 000 drives the local output value bit.
// (R6) With device status as source, select 001 drives the OR of lock over enabled receive ports.
// (R7) With device status as source, select 010 drives the AND of pass over enabled receive ports.
// (R8) With device status as source, select 100 drives the frame sync pulse; 101-111 are reserved.
// (R9) With the transmit port as source, select 000 drives AND and 001 OR of selected ports' pass.
// (R10) With the transmit port as source, select 010 drives frame valid and 011 line valid.
// (R11) With the transmit port as source, 100 drives synchronized, 101 interrupt, 110-111 are reserved.
// (R12) Bit 1 is the level driven when the local register value is selected.
// (R13) Bit 0 enables the pin driver, 0 off and 1 on.
// (R14) Select sits in bits 7:5 and every control field resets to zero, leaving the driver off.
// (R15) The control register has index 0x15 and resets to 0x00.
// (R16) Reserved or unlisted source and select codes drive a constant low.
// (R17) While the enable bit is clear the driver stays off whatever source and select say.
module gpm_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // receive port signals
    input wire logic [3:0][3:0] rx_remote_pin_i,
    input wire logic [3:0] rx_lock_i,
    input wire logic [3:0] rx_pass_i,
    input wire logic [3:0] rx_frame_valid_i,
    input wire logic [3:0] rx_line_valid_i,
    // device and transmit signals
    input wire logic frame_sync_pulse_i,
    input wire logic tx_frame_valid_i,
    input wire logic tx_line_valid_i,
    input wire logic tx_synced_i,
    input wire logic tx_irq_i,
    // pin driver
    output logic pin_out_o,
    output logic pin_oe_o
);
    gpm_cfg_if cfg ();

    logic [7:0] pin_ctrl_q;
    logic [7:0] pin_ctrl_d;
    logic [7:0] port_cfg_q;
    logic [7:0] port_cfg_d;
    logic pready_q;
    logic pready_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic pin_out_q;
    logic pin_out_d;
    logic pin_oe_q;
    logic pin_oe_d;
    logic access_w;
    logic finish_w;
    logic mux_w;
    logic lock_any_w;
    logic pass_all_w;
    logic tx_pass_and_w;
    logic tx_pass_or_w;
    logic [2:0] src_w;
    logic [2:0] sel_w;
    logic oe_w;
    logic [3:0] en_w;
    logic [3:0] txsel_w;

    assign src_w = pin_ctrl_q[gpm_pkg::CTRL_SRC_MSB:gpm_pkg::CTRL_SRC_LSB];
    assign sel_w = pin_ctrl_q[gpm_pkg::CTRL_SEL_MSB:gpm_pkg::CTRL_SEL_LSB];
    assign oe_w = pin_ctrl_q[gpm_pkg::CTRL_OE_BIT];
    assign en_w = port_cfg_q[gpm_pkg::CFG_EN_MSB:gpm_pkg::CFG_EN_LSB];
    assign txsel_w = port_cfg_q[gpm_pkg::CFG_TXSEL_MSB:gpm_pkg::CFG_TXSEL_LSB];

    assign cfg.pin_ctrl = pin_ctrl_q;
    assign cfg.rx_enable = en_w;
    assign cfg.tx_pass_sel = txsel_w;

    // one wait state: decode in the first access cycle, complete in the second
    assign access_w = psel_i && penable_i && !pready_q;
    assign finish_w = psel_i && penable_i && pready_q;

    always_comb begin
        pin_ctrl_d = pin_ctrl_q;
        port_cfg_d = port_cfg_q;
        pready_d = 1'b0;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (access_w) begin
            pready_d = 1'b1;
            prdata_d = gpm_pkg::RDATA_ZERO;
            unique case (paddr_i)
                gpm_pkg::ADDR_PIN_CTRL: begin
                    if (!pwrite_i) begin
                        prdata_d = {gpm_pkg::PAD24, pin_ctrl_q};
                    end
                end
                gpm_pkg::ADDR_PORT_CFG: begin
                    if (!pwrite_i) begin
                        prdata_d = {gpm_pkg::PAD24, port_cfg_q};
                    end
                end
                gpm_pkg::ADDR_PIN_STATUS: begin
                    // status is read only; a write is answered with an error
                    pslverr_d = pwrite_i;
                    if (!pwrite_i) begin
                        prdata_d = {gpm_pkg::PAD30, pin_out_q, pin_oe_q};
                    end
                end
                default: pslverr_d = 1'b1;
            endcase
        end else if (finish_w) begin
            pslverr_d = pslverr_q;
            // writes land only on the completing edge
            if (pwrite_i && !pslverr_q && pstrb_i[0]) begin
                if (paddr_i == gpm_pkg::ADDR_PIN_CTRL) begin
                    pin_ctrl_d = pwdata_i[7:0]; // [R15]
                end
                if (paddr_i == gpm_pkg::ADDR_PORT_CFG) begin
                    port_cfg_d = pwdata_i[7:0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pin_ctrl_q <= gpm_pkg::PIN_CTRL_RESET; // [R14] [R15]
            port_cfg_q <= gpm_pkg::PORT_CFG_RESET;
            pready_q <= 1'b0;
            prdata_q <= gpm_pkg::RDATA_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            pin_ctrl_q <= pin_ctrl_d;
            port_cfg_q <= port_cfg_d;
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign pready_o = pready_q;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;

    gpm_port_reduce u_reduce (
        .lock_i(rx_lock_i),
        .pass_i(rx_pass_i),
        .enable_i(cfg.rx_enable),
        .tx_sel_i(cfg.tx_pass_sel),
        .lock_any_o(lock_any_w),
        .pass_all_o(pass_all_w),
        .tx_pass_and_o(tx_pass_and_w),
        .tx_pass_or_o(tx_pass_or_w)
    );

    gpm_src_mux u_mux (
        .cfg(cfg),
        .rx_remote_pin_i(rx_remote_pin_i),
        .rx_lock_i(rx_lock_i),
        .rx_pass_i(rx_pass_i),
        .rx_frame_valid_i(rx_frame_valid_i),
        .rx_line_valid_i(rx_line_valid_i),
        .lock_any_i(lock_any_w),
        .pass_all_i(pass_all_w),
        .tx_pass_and_i(tx_pass_and_w),
        .tx_pass_or_i(tx_pass_or_w),
        .frame_sync_pulse_i(frame_sync_pulse_i),
        .tx_frame_valid_i(tx_frame_valid_i),
        .tx_line_valid_i(tx_line_valid_i),
        .tx_synced_i(tx_synced_i),
        .tx_irq_i(tx_irq_i),
        .mux_o(mux_w)
    );

    // data is forced low while disabled so a later enable never shows stale data
    always_comb begin
        pin_oe_d = oe_w; // [R13] [R17]
        pin_out_d = oe_w ? mux_w : 1'b0; // [R17]
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pin_oe_q <= 1'b0;
            pin_out_q <= 1'b0;
        end else begin
            pin_oe_q <= pin_oe_d;
            pin_out_q <= pin_out_d;
        end
    end

    assign pin_oe_o = pin_oe_q;
    assign pin_out_o = pin_out_q;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    a_driver_off_disabled: assert property ( // [R13] [R17]
        !oe_w |=> !pin_oe_o && !pin_out_o
    ) else $error("pin driven while enable bit clear");

    a_driver_on_enabled: assert property ( // [R13]
        oe_w ##1 oe_w |=> pin_oe_o [*1]
    ) else $error("pin driver off while enabled");

    a_rx_pin_route: assert property ( // [R1] [R2]
        oe_w && !src_w[2] && !sel_w[2]
        |=> pin_out_o == $past(rx_remote_pin_i[src_w[1:0]][sel_w[1:0]])
    ) else $error("remote pin not routed");

    a_rx_lock_pass: assert property ( // [R3]
        oe_w && !src_w[2] && sel_w[2:1] == 2'h2
        |=> pin_out_o == $past(sel_w[0] ? rx_pass_i[src_w[1:0]] : rx_lock_i[src_w[1:0]])
    ) else $error("receive lock or pass not routed");

    a_rx_video_valid: assert property ( // [R4]
        oe_w && !src_w[2] && sel_w[2:1] == 2'h3
        |=> pin_out_o ==
            $past(sel_w[0] ? rx_line_valid_i[src_w[1:0]] : rx_frame_valid_i[src_w[1:0]])
    ) else $error("receive video valid not routed");

    a_local_value: assert property ( // [R5] [R12]
        oe_w && src_w == gpm_pkg::SRC_STATUS && sel_w == gpm_pkg::SEL_ST_VAL
        |=> pin_out_o == $past(pin_ctrl_q[gpm_pkg::CTRL_VAL_BIT])
    ) else $error("local output value not driven");

    a_lock_any: assert property ( // [R6]
        oe_w && src_w == gpm_pkg::SRC_STATUS && sel_w == gpm_pkg::SEL_ST_LOCK_ANY
        |=> pin_out_o == $past(|(rx_lock_i & en_w))
    ) else $error("lock or of enabled ports wrong");

    a_pass_all: assert property ( // [R7]
        oe_w && src_w == gpm_pkg::SRC_STATUS && sel_w == gpm_pkg::SEL_ST_PASS_ALL
        |=> pin_out_o == $past(&(rx_pass_i | ~en_w))
    ) else $error("pass and of enabled ports wrong");

    a_frame_sync: assert property ( // [R8]
        oe_w && src_w == gpm_pkg::SRC_STATUS && sel_w == gpm_pkg::SEL_ST_FSYNC
        |=> pin_out_o == $past(frame_sync_pulse_i)
    ) else $error("frame sync not routed");

    a_tx_pass: assert property ( // [R9]
        oe_w && src_w == gpm_pkg::SRC_TX && sel_w[2:1] == 2'h0
        |=> pin_out_o ==
            $past(sel_w[0] ? |(rx_pass_i & txsel_w) : &(rx_pass_i | ~txsel_w))
    ) else $error("transmit pass reduction wrong");

    a_tx_video: assert property ( // [R10]
        oe_w && src_w == gpm_pkg::SRC_TX && sel_w[2:1] == 2'h1
        |=> pin_out_o == $past(sel_w[0] ? tx_line_valid_i : tx_frame_valid_i)
    ) else $error("transmit video valid not routed");

    a_tx_sync_irq: assert property ( // [R11]
        oe_w && src_w == gpm_pkg::SRC_TX && sel_w[2:1] == 2'h2
        |=> pin_out_o == $past(sel_w[0] ? tx_irq_i : tx_synced_i)
    ) else $error("transmit sync or interrupt not routed");

    a_reserved_low: assert property ( // [R16]
        (src_w == 3'h5 || src_w == 3'h7
         || (src_w == gpm_pkg::SRC_TX && sel_w[2:1] == 2'h3)
         || (src_w == gpm_pkg::SRC_STATUS && (sel_w == 3'h3 || sel_w > 3'h4)))
        |=> !pin_out_o
    ) else $error("reserved code not driving low");

    a_reset_clear: assert property ( // [R14]
        $past(!rst_b_i) |-> pin_ctrl_q == gpm_pkg::PIN_CTRL_RESET && !pin_oe_o && !pin_out_o
    ) else $error("control not cleared by reset");

    a_ctrl_write: assert property ( // [R15]
        finish_w && pwrite_i && !pslverr_q && pstrb_i[0] && paddr_i == gpm_pkg::ADDR_PIN_CTRL
        |=> pin_ctrl_q == $past(pwdata_i[7:0])
    ) else $error("control write not taken");

    a_apb_wait_one: assert property (
        access_w |=> pready_o ##1 !pready_o
    ) else $error("apb answer not one wait state");
endmodule

/* verification/gpm_board.sv */
/*
 * board-side model of the net behind the multiplexed output pin.
 * assumes a pull-down on the board net and no other driver on it.
 */
module gpm_board (
    // pin driver seen from the board
    input wire logic pin_out_i,
    input wire logic pin_oe_i,
    // level on the board net
    output logic pin_level_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // undriven net falls to the pull-down, never holds the last value
    assign pin_level_o = pin_oe_i ? pin_out_i : 1'b0;
endmodule

/* verification/gpio_pin_output_source_mux_bench.sv */
/*
 * self-checking bench for the pin output source multiplexer.
 * assumes gpm_top with a one-wait-state apb slave and a registered pin path.
 */
module gpio_pin_output_source_mux_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
    logic pin_out, pin_oe, pin_level;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [36:0] stim_q;
    logic [7:0] cfg_q;
    int failures, n_tests;

    gpm_top DUT (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .rx_remote_pin_i(stim_q[15:0]), .rx_lock_i(stim_q[19:16]),
        .rx_pass_i(stim_q[23:20]), .rx_frame_valid_i(stim_q[27:24]),
        .rx_line_valid_i(stim_q[31:28]), .frame_sync_pulse_i(stim_q[32]),
        .tx_frame_valid_i(stim_q[33]), .tx_line_valid_i(stim_q[34]),
        .tx_synced_i(stim_q[35]), .tx_irq_i(stim_q[36]),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe));

    gpm_board u_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_level_o(pin_level));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // holds the whole request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, s, rd, err);
        cmp_bit(err, exp_err, "write error flag");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        // strobes stay low on reads
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        cmp_bit(err, exp_err, "read error flag");
        cmp_word(rd, exp, "read data");
    endtask

    // expected pin level, built from the field encodings alone
    function automatic logic ref_pin(input logic [7:0] c, input logic [36:0] p,
                                     input logic [7:0] g);
        logic [2:0] src;
        logic [2:0] sel;
        src = c[4:2];
        sel = c[7:5];
        if (c[0] !== 1'b1) return 1'b0;
        if (src[2] === 1'b0)
            return p[{sel[2], sel[2] ? {sel[1:0], src[1:0]} : {src[1:0], sel[1:0]}}];
        if (src === gpm_pkg::SRC_STATUS) begin
            case (sel)
                3'h0: return c[1];
                3'h1: return |(p[19:16] & g[3:0]);
                3'h2: return &(p[23:20] | ~g[3:0]);
                3'h4: return p[32];
                default: return 1'b0;
            endcase
        end
        if (src === gpm_pkg::SRC_TX) begin
            case (sel)
                3'h0: return &(p[23:20] | ~g[7:4]);
                3'h1: return |(p[23:20] & g[7:4]);
                3'h2: return p[33];
                3'h3: return p[34];
                3'h4: return p[35];
                3'h5: return p[36];
                default: return 1'b0;
            endcase
        end
        return 1'b0;
    endfunction

    // every select, enable and local value for one source, four input patterns each
    task automatic sweep(input logic [2:0] src);
        logic [7:0] c;
        logic [36:0] p;
        for (int k = 0; k < 32; k++) begin
            c = {k[4:2], src, k[1:0]};
            wr_chk(gpm_pkg::ADDR_PIN_CTRL, {24'h00_0000, c}, 4'hF, 1'b0);
            for (int j = 0; j < 4; j++) begin
                // lock and pass digits chosen so masking changes the reductions
                p = (j == 0) ? 37'h00_0000_0000 : 37'h0A_5C69_6E1B;
                if (j == 1) p = ~37'h00_0000_0000;
                if (j == 3) p = ~p;
                @(posedge clk_sys_i);
                stim_q <= p;
                @(posedge clk_sys_i);
                #1;
                cmp_bit(pin_oe, c[0], "driver enable");
                cmp_bit(pin_out, ref_pin(c, p, cfg_q), "pin value");
                cmp_bit(pin_level, ref_pin(c, p, cfg_q), "board level");
            end
        end
    endtask

    task automatic s_reset;
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        cfg_q = 8'hFF;
        @(posedge clk_sys_i);
        #1;
        cmp_bit(pin_oe, 1'b0, "enable after reset");
        cmp_bit(pin_out, 1'b0, "pin after reset");
        rd_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_0000, 1'b0);
        rd_chk(gpm_pkg::ADDR_PORT_CFG, 32'h0000_00FF, 1'b0);
    endtask

    task automatic s_regs_errors;
        wr_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_00FF, 4'hF, 1'b0);
        rd_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_00FF, 1'b0);
        wr_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_0000, 4'h0, 1'b0);
        rd_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_00FF, 1'b0);
        rd_chk(gpm_pkg::ADDR_PIN_STATUS, 32'h0000_0001, 1'b0);
        wr_chk(gpm_pkg::ADDR_PIN_STATUS, 32'h0000_0000, 4'hF, 1'b1);
        rd_chk(12'h100, 32'h0000_0000, 1'b1);
        wr_chk(12'h055, 32'h0000_0000, 4'hF, 1'b1);
        wr_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_0013, 4'hF, 1'b0);
        rd_chk(gpm_pkg::ADDR_PIN_STATUS, 32'h0000_0003, 1'b0);
    endtask

    task automatic s_rx_sources;
        for (int s = 0; s < 4; s++) begin
            sweep(s[2:0]);
        end
    endtask

    task automatic s_masked_sources;
        wr_chk(gpm_pkg::ADDR_PORT_CFG, 32'h0000_0096, 4'hF, 1'b0);
        cfg_q = 8'h96;
        sweep(gpm_pkg::SRC_STATUS);
        sweep(gpm_pkg::SRC_TX);
        sweep(3'h5);
        sweep(3'h7);
    endtask

    // reset in mid-run must drop a driving pin
    task automatic s_reset_mid;
        wr_chk(gpm_pkg::ADDR_PIN_CTRL, 32'h0000_0013, 4'hF, 1'b0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        cmp_bit(pin_level, 1'b1, "local value driven");
        s_reset();
    endtask

    initial begin
        failures = 0;
        n_tests = 0;
        rst_b_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        stim_q = 37'h00_0000_0000;
        cfg_q = 8'hFF;
        s_reset();
        s_regs_errors();
        s_rx_sources();
        s_masked_sources();
        s_reset_mid();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        give_verdict();
    end
endmodule
